//--- rtl/wrc_top.sv
// supervisory block: guard timer, reset generator, clock generator, power-down gating
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wrc_top
   import wrc_pkg::*;
#(
   parameter int unsigned POR_CYCLES = POR_CYCLES_DEF,    // power-on reset length in cycles
   parameter int unsigned PERIOD_SHIFT = PERIOD_SHIFT_DEF // log2 of the shortest period
) (
   input wire logic pclk,                // system clock, 200 MHz
   input wire logic presetn,             // async reset, supply valid when high
   input wire logic psel,                // apb select
   input wire logic penable,             // apb access phase
   input wire logic pwrite,              // apb direction
   input wire logic [7:0] paddr,         // apb byte address
   input wire logic [31:0] pwdata,       // apb write data
   output logic [31:0] prdata,           // apb read data
   output logic pready,                  // apb ready
   output logic pslverr,                 // apb error on unmapped address
   input wire logic reset_pin_in,        // level seen on the reset pin
   output logic reset_pin_out,           // open-drain drive value, always low
   output logic reset_pin_oe,            // high while pulling the reset pin low
   output logic timeout_alarm_n,         // guard timer alarm, active low
   input wire logic halt_req,            // halt executed by the cpu
   input wire logic wake_req,            // wake event ending a power-down state
   output logic clock_gen_output,        // generated clock as enable pulses
   output logic cpu_clk_en,              // cpu clock enable
   output logic ctc_clk_en,              // counter_timer_unit clock enable
   output logic periph_clk_en,           // parallel_port_unit and serial_channel_unit enable
   output logic guard_clk_en             // runaway_guard_timer clock enable
);
   ////////////////////////////////////////////////////////////////////////
   // declarations
   wrc_apb_req_t req;                    // bundled apb request
   wrc_mode_t mode_q;                    // guard_timer_mode_reg
   wrc_misc_t misc_q;                    // misc_control_reg
   wrc_power_t power_q;                  // power control register
   wrc_pwr_t pwr_q;                      // current power state
   wrc_pwr_t next_pwr;                   // next power state
   logic wr_access;                      // write in access phase
   logic setup_phase;                    // first cycle of a transfer
   logic addr_hit;                       // address maps to a register
   logic clear_req;                      // software clear of the guard timer
   logic [31:0] rd_mux;                  // read data selection
   logic rst_s1, rst_s2, rst_s3;         // reset pin synchroniser
   logic rst_level;                      // filtered reset pin level
   logic rst_level_d;                    // previous filtered level
   logic ext_fall;                       // falling edge from outside
   logic por_busy;                       // power-on interval running
   logic [31:0] por_cnt;                 // power-on interval counter
   logic [4:0] ext_left;                 // remaining stretch cycles
   logic [4:0] next_ext_left;            // next stretch count
   logic [31:0] count;                   // guard counter
   logic [31:0] period_end;              // last count of the period
   logic guard_run;                      // guard counter advancing
   logic timeout_hit;                    // period elapsed this cycle
   logic [2:0] pulse_left;               // remaining alarm pulse cycles
   logic div_bypass_eff;                 // divide stage skipped
   logic div_phase;                      // divide-by-two phase
   logic first_seen;                     // one edge passed since reset
   ////////////////////////////////////////////////////////////////////////
   // apb decode
   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
   assign wr_access = req.sel && req.enable && req.write;
   assign setup_phase = req.sel && !req.enable;
   assign addr_hit = (req.addr == MODE_OFS) || (req.addr == MISC_OFS) ||
                     (req.addr == CLEAR_OFS) || (req.addr == POWER_OFS) ||
                     (req.addr == STATUS_OFS);
   assign clear_req = wr_access && (req.addr == CLEAR_OFS) && req.wdata[CLEAR_BIT];

   // read data selection, reserved bits zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (req.addr)
         MODE_OFS: rd_mux = {24'h00_0000, mode_q & 8'h17};
         MISC_OFS: rd_mux = {24'h00_0000, misc_q & 8'h09};
         POWER_OFS: rd_mux = {24'h00_0000, power_q & 8'h07};
         STATUS_OFS: rd_mux = {count[23:0], 3'h0, reset_pin_oe, pwr_q, por_busy,
                               !timeout_alarm_n};
         default: rd_mux = 32'h0000_0000;   // clear register and holes read zero
      endcase
   end

   // apb answer registered in the setup cycle, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setup_phase) begin
            prdata <= req.write ? 32'h0000_0000 : rd_mux;
            pslverr <= !addr_hit;
         end
      end
   end

   // register writes take effect in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= MODE_RESET;
         misc_q <= MISC_RESET;
         power_q <= POWER_RESET;
      end else if (wr_access) begin
         case (req.addr)
            MODE_OFS: mode_q <= req.wdata[7:0] & 8'h17;
            MISC_OFS: misc_q <= req.wdata[7:0] & 8'h09;
            POWER_OFS: power_q <= req.wdata[7:0] & 8'h07;
            default: ;                                   // status and clear hold no bits
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // reset pin: three-stage synchroniser, change accepted when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
         rst_s3 <= 1'b0;
         rst_level <= 1'b0;
         rst_level_d <= 1'b0;
      end else begin
         rst_s1 <= reset_pin_in;
         rst_s2 <= rst_s1;
         rst_s3 <= rst_s2;
         if (rst_s2 == rst_s3) begin
            rst_level <= rst_s3;
         end
         rst_level_d <= rst_level;
      end
   end
   assign ext_fall = rst_level_d && !rst_level && !reset_pin_oe;

   // power-on interval, counted from the release of presetn
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt <= 32'h0000_0000;
         por_busy <= 1'b1;
      end else if (por_busy) begin
         if (por_cnt == 32'(POR_CYCLES - 1)) begin
            por_busy <= 1'b0;
         end else begin
            por_cnt <= por_cnt + 32'h0000_0001;
         end
      end
   end

   // stretch after an external falling edge, only once the power-on interval is over
   always_comb begin
      next_ext_left = ext_left;
      if (misc_q.reset_inhibit) begin
         next_ext_left = 5'h00;
      end else if (ext_fall && !por_busy) begin
         next_ext_left = 5'(EXT_RESET_CYCLES);
      end else if (ext_left != 5'h00) begin
         next_ext_left = ext_left - 5'h01;
      end
   end

   // open-drain reset driver
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_left <= 5'h00;
         reset_pin_out <= 1'b0;
         reset_pin_oe <= 1'b1;
      end else begin
         ext_left <= next_ext_left;
         reset_pin_out <= 1'b0;
         reset_pin_oe <= !misc_q.reset_inhibit &&
                         (por_busy || next_ext_left != 5'h00);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // guard counter
   assign guard_run = mode_q.enable && (pwr_q == PWR_RUN);
   assign period_end = (32'h0000_0001 << (PERIOD_SHIFT + 2 * mode_q.period)) - 32'h0000_0001;
   // at or past the end: a period shortened under a running count still times out
   assign timeout_hit = guard_run && (count >= period_end);

   // counts system clocks, restarts on clear, external reset or disable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 32'h0000_0000;
      end else if (clear_req || !rst_level || !mode_q.enable) begin
         count <= 32'h0000_0000;
      end else if (guard_run) begin
         count <= timeout_hit ? 32'h0000_0000 : count + 32'h0000_0001;
      end
   end

   // alarm pin: timed pulse when wired to reset, latched level otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_alarm_n <= 1'b1;
         pulse_left <= 3'h0;
      end else if (timeout_hit) begin
         timeout_alarm_n <= 1'b0;                      // set wins over clear
         pulse_left <= 3'(ALARM_PULSE_CYCLES - 1);
      end else if (!timeout_alarm_n) begin
         if (misc_q.alarm_to_reset) begin
            if (pwr_q == PWR_RUN) begin
               if (pulse_left == 3'h0) begin
                  timeout_alarm_n <= 1'b1;
               end else begin
                  pulse_left <= pulse_left - 3'h1;
               end
            end
         end else if (clear_req || !rst_level) begin
            timeout_alarm_n <= 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // power state machine
   always_comb begin
      next_pwr = pwr_q;
      case (pwr_q)
         PWR_RUN: begin
            if (halt_req) begin
               if (power_q.clk_src_ext && power_q.halt_target != PWR_RUN) begin
                  next_pwr = PWR_TIMER_ALIVE_IDLE;
               end else begin
                  next_pwr = power_q.halt_target;
               end
            end
         end
         PWR_FULL_IDLE, PWR_TIMER_ALIVE_IDLE, PWR_STOP: begin
            if (wake_req || !rst_level) begin
               next_pwr = PWR_RUN;
            end
         end
         default: next_pwr = PWR_RUN;
      endcase
   end

   // state register and unit clock enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_q <= PWR_RUN;
         cpu_clk_en <= 1'b0;
         ctc_clk_en <= 1'b0;
         periph_clk_en <= 1'b0;
         guard_clk_en <= 1'b0;
      end else begin
         pwr_q <= next_pwr;
         cpu_clk_en <= (next_pwr == PWR_RUN);
         periph_clk_en <= (next_pwr == PWR_RUN);
         guard_clk_en <= (next_pwr == PWR_RUN);
         ctc_clk_en <= (next_pwr == PWR_RUN) || (next_pwr == PWR_TIMER_ALIVE_IDLE);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // clock_gen_unit: enable pulses at half or full rate, not used inside the block
   assign div_bypass_eff = mode_q.div_bypass && !power_q.clk_src_ext;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_phase <= 1'b0;
         clock_gen_output <= 1'b0;
      end else if (pwr_q == PWR_STOP && !power_q.clk_src_ext) begin
         div_phase <= 1'b0;                 // oscillator stopped
         clock_gen_output <= 1'b0;
      end else begin
         div_phase <= !div_phase;
         clock_gen_output <= div_bypass_eff || div_phase;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // assertions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_seen <= 1'b0;
      end else begin
         first_seen <= 1'b1;
      end
   end

   a_guard_up_enabled: assert property (@(posedge pclk) disable iff (!presetn)
      !first_seen |-> mode_q.enable && timeout_alarm_n)
      else $error("guard timer not enabled after reset");
   a_guard_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      (pwr_q != PWR_RUN) && !clear_req && rst_level && mode_q.enable |=> $stable(count))
      else $error("guard counter moved in power-down");
   a_alarm_on_timeout: assert property (@(posedge pclk) disable iff (!presetn)
      guard_run && count == period_end |=> !timeout_alarm_n && count == 32'h0000_0000)
      else $error("no alarm at end of period");
   a_alarm_pulse_five: assert property (@(posedge pclk)
      disable iff (!presetn || pwr_q != PWR_RUN || !misc_q.alarm_to_reset)
      $fell(timeout_alarm_n) |-> !timeout_alarm_n[*5] ##1 timeout_alarm_n)
      else $error("alarm pulse not five cycles");
   a_alarm_latched: assert property (@(posedge pclk) disable iff (!presetn)
      !timeout_alarm_n && !misc_q.alarm_to_reset && !clear_req && rst_level
      |=> !timeout_alarm_n)
      else $error("latched alarm released early");
   a_por_full_length: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(por_busy) |-> $past(por_cnt) == 32'(POR_CYCLES - 1))
      else $error("power-on interval wrong length");
   a_por_release: assert property (@(posedge pclk) disable iff (!presetn)
      !por_busy && !$past(por_busy) && ext_left == 5'h00 && $past(ext_left) == 5'h00
      |-> !reset_pin_oe)
      else $error("reset driver not released");
   a_ext_stretch: assert property (@(posedge pclk) disable iff (!presetn)
      ext_fall && !por_busy && !misc_q.reset_inhibit ##1 !misc_q.reset_inhibit[*8]
      |-> reset_pin_oe[*8])
      else $error("external reset not stretched");
   a_inhibit_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      misc_q.reset_inhibit |=> !reset_pin_oe)
      else $error("reset pin driven while inhibited");
   a_clk_halved: assert property (@(posedge pclk) disable iff (!presetn)
      !div_bypass_eff && clock_gen_output && $stable(div_bypass_eff) |=> !clock_gen_output)
      else $error("clock output not halved");
   a_clk_bypass: assert property (@(posedge pclk) disable iff (!presetn)
      div_bypass_eff && pwr_q != PWR_STOP ##1 div_bypass_eff |-> clock_gen_output)
      else $error("divide stage not bypassed");
   a_stop_reachable: assert property (@(posedge pclk) disable iff (!presetn)
      pwr_q == PWR_RUN && halt_req && !power_q.clk_src_ext &&
      power_q.halt_target == PWR_STOP |=> pwr_q == PWR_STOP)
      else $error("halt state not entered");
   a_ext_clk_idle: assert property (@(posedge pclk) disable iff (!presetn)
      power_q.clk_src_ext && $stable(power_q) && pwr_q != PWR_RUN && $past(pwr_q) == PWR_RUN
      |-> pwr_q == PWR_TIMER_ALIVE_IDLE)
      else $error("illegal power-down with external clock");
   a_ctc_alive: assert property (@(posedge pclk) disable iff (!presetn)
      pwr_q == PWR_TIMER_ALIVE_IDLE |-> ctc_clk_en && !cpu_clk_en && !periph_clk_en &&
      !guard_clk_en)
      else $error("timer-alive idle gating wrong");
   a_clear_restart: assert property (@(posedge pclk) disable iff (!presetn)
      clear_req |=> count == 32'h0000_0000 ##1 (!guard_run || count <= 32'h0000_0001))
      else $error("clear did not restart counter");

   c_pulse_alarm: cover property (@(posedge pclk) disable iff (!presetn)
      $fell(timeout_alarm_n) && misc_q.alarm_to_reset);
   c_latched_cleared: cover property (@(posedge pclk) disable iff (!presetn)
      !timeout_alarm_n && !misc_q.alarm_to_reset && clear_req);
   c_ext_stretch: cover property (@(posedge pclk) disable iff (!presetn)
      ext_fall && !por_busy && !misc_q.reset_inhibit);
   c_timer_idle: cover property (@(posedge pclk) disable iff (!presetn)
      pwr_q == PWR_TIMER_ALIVE_IDLE);
endmodule
`default_nettype wire

//--- include/wrc_pkg.sv
// shared constants, register layouts and types of the supervisory block
package wrc_pkg;
   ////////////////////////////////////////////////////////////////////////
   // register byte offsets on the apb slave
   localparam logic [7:0] MODE_OFS = 8'h00;     // guard_timer_mode_reg
   localparam logic [7:0] MISC_OFS = 8'h04;     // misc_control_reg
   localparam logic [7:0] CLEAR_OFS = 8'h08;    // guard timer clear command
   localparam logic [7:0] POWER_OFS = 8'h0C;    // power-down and clock source control
   localparam logic [7:0] STATUS_OFS = 8'h10;   // read-only block state
   // values after power-on reset
   localparam logic [7:0] MODE_RESET = 8'h01;   // guard enabled, period field 0 (shortest period), divide by two
   localparam logic [7:0] MISC_RESET = 8'h00;   // reset output allowed
   localparam logic [7:0] POWER_RESET = 8'h00;  // halt target run, on-chip clock source
   // field position of the clear command bit
   localparam int CLEAR_BIT = 0;
   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int unsigned CLK_HZ = 200_000_000;       // pclk rate
   localparam int unsigned POR_TIME_MS = 50;           // power-on drive, within 25..75 ms
   localparam int unsigned POR_CYCLES_DEF = POR_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned ALARM_PULSE_CYCLES = 5;     // alarm low time when wired to reset
   localparam int unsigned EXT_RESET_CYCLES = 16;      // reset stretch after external edge
   localparam int unsigned PERIOD_SHIFT_DEF = 16;      // period = 2^(shift + 2*field)
   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      PWR_RUN = 2'b00,              // normal operation
      PWR_FULL_IDLE = 2'b01,        // full_idle_state
      PWR_TIMER_ALIVE_IDLE = 2'b10, // timer_alive_idle_state
      PWR_STOP = 2'b11              // oscillator stopped
   } wrc_pwr_t;
   typedef struct packed {
      logic [2:0] rsv_hi;           // bits 7:5 read zero
      logic div_bypass;             // bit 4, skip the divide-by-two stage
      logic rsv3;                   // bit 3 reads zero
      logic [1:0] period;           // bits 2:1, timeout_period_field
      logic enable;                 // bit 0, guard timer running
   } wrc_mode_t;
   typedef struct packed {
      logic [3:0] rsv_hi;           // bits 7:4 read zero
      logic reset_inhibit;          // bit 3, no on-chip drive of the reset pin
      logic [1:0] rsv_lo;           // bits 2:1 read zero
      logic alarm_to_reset;         // bit 0, alarm pin is wired to the reset pin
   } wrc_misc_t;
   typedef struct packed {
      logic [4:0] rsv_hi;           // bits 7:3 read zero
      logic clk_src_ext;            // bit 2, system clock from an external source
      wrc_pwr_t halt_target;        // bits 1:0, state entered on halt
   } wrc_power_t;
   typedef struct packed {
      logic sel;                    // psel
      logic enable;                 // penable
      logic write;                  // pwrite
      logic [7:0] addr;             // paddr
      logic [31:0] wdata;           // pwdata
   } wrc_apb_req_t;
endpackage

//--- testbench/wrc_reset_net.sv
// reset net partner: pull-up, device open-drain drive, external reset source
`timescale 1ns/1ps
`default_nettype none
module wrc_reset_net (
   input wire logic reset_pin_out, // device drive value
   input wire logic reset_pin_oe,  // device pulls the net
   input wire logic ext_low,       // external source pulls low
   output logic reset_pin_in       // resolved net level
);
   // pull-up wins only while nobody drives the net
   assign reset_pin_in = ((reset_pin_oe && !reset_pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

//--- testbench/test_wrc_top.sv
// self-checking bench of the supervisory block with a register model
`timescale 1ns/1ps
`default_nettype none
module test_wrc_top;
   import wrc_pkg::*;
   localparam int POR = 20; // shortened power-on interval
   localparam int SHIFT = 3; // shortest period of eight cycles outlasts the alarm pulse
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, rd0, seed = 32'h9C06700F;
   logic pready, pslverr, er, pin_in, pin_out, pin_oe, alarm_n, cg, cpu_en, ctc_en, per_en, grd_en;
   logic halt_req = 0, wake_req = 0, ext_low = 0;
   int err_count = 0, checked = 0, cyc = 0, n, p;
   logic [31:0] mdl [0:4] = '{32'(MODE_RESET), 32'(MISC_RESET), 32'h0, 32'(POWER_RESET), 32'h0};
   wrc_top #(.POR_CYCLES(POR), .PERIOD_SHIFT(SHIFT)) i_wrc_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin_in(pin_in),
      .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .timeout_alarm_n(alarm_n),
      .halt_req(halt_req), .wake_req(wake_req), .clock_gen_output(cg), .cpu_clk_en(cpu_en),
      .ctc_clk_en(ctc_en), .periph_clk_en(per_en), .guard_clk_en(grd_en));
   wrc_reset_net i_wrc_reset_net (.reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
      .ext_low(ext_low), .reset_pin_in(pin_in));
   ////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial forever #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [31:0] msk(input logic [7:0] a);
      return (a == MODE_OFS) ? 32'h17 : (a == MISC_OFS) ? 32'h09 : 32'h07;
   endfunction
   task automatic stop_test();
      if (err_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checked++;
      if (got !== ex) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic tk(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // one apb transfer, request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      tk(1);
      penable <= 1;
      tk(1);
      while (pready !== 1'b1) tk(1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (w && a != CLEAR_OFS && a < STATUS_OFS) mdl[a[4:2]] = d & msk(a);
      tk(1); // idle edge, so a following setup never reassigns psel in this step
   endtask
   task automatic rdchk(input logic [7:0] a);
      apb(0, a, 32'h0);
      chk("prdata", mdl[a[4:2]], rd);
   endtask
   task automatic pulse_low_count(); // counts cycles with the reset drive on
      n = 0;
      while (pin_oe !== 1'b1 && n < 20) begin tk(1); n++; end
      n = 0;
      while (pin_oe === 1'b1 && n < 60) begin tk(1); n++; end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      tk(12);
      presetn <= 1;
      n = 0;
      while (pin_oe === 1'b1 && n < 100) begin tk(1); n++; end
      // count starts at the release edge and reads lag one edge: drive cycles plus two
      chk("por_len", 1, 32'(n >= POR + 1 && n <= POR + 3));
      tk(4);
      chk("net_level", 1, 32'(pin_in));
      chk("drive_value", 0, 32'(pin_out));
      for (int a = 0; a < 3; a++) rdchk(8'(a * 4 + (a == 2) * 4));
      n = 0;
      repeat (8) begin tk(1); n += (cg === 1'b1); end
      chk("div2_pulses", 4, n);
      apb(1, MODE_OFS, 32'h11);
      n = 0;
      repeat (8) begin tk(1); n += (cg === 1'b1); end
      chk("div1_pulses", 8, n);
      repeat (6) begin
         seed = xs(seed);
         p = seed[1:0] % 3;
         apb(1, 8'(p * 4 + (p == 2) * 4), seed);
         rdchk(8'(p * 4 + (p == 2) * 4));
      end
      apb(0, 8'h14, 32'h0);
      chk("unmapped_err", 1, 32'(er));
      chk("unmapped_rd", 0, rd);
      apb(1, MISC_OFS, 32'h0);
      apb(1, POWER_OFS, 32'h0);
      apb(1, MODE_OFS, 32'h03);
      apb(1, CLEAR_OFS, 32'h1);
      p = 1 << (SHIFT + 2 * 1);
      n = 0;
      while (alarm_n !== 1'b0 && n < 100) begin tk(1); n++; end
      chk("timeout_len", 1, 32'(n >= p && n <= p + 2));
      tk(40);
      chk("alarm_held", 0, 32'(alarm_n));
      apb(1, CLEAR_OFS, 32'h1);
      tk(2);
      chk("alarm_clear", 1, 32'(alarm_n));
      apb(1, MISC_OFS, 32'h1);
      apb(1, CLEAR_OFS, 32'h1);
      n = 0;
      while (alarm_n !== 1'b0 && n < 100) begin tk(1); n++; end
      n = 0;
      while (alarm_n === 1'b0 && n < 50) begin tk(1); n++; end
      chk("alarm_pulse", ALARM_PULSE_CYCLES, n);
      apb(1, MODE_OFS, 32'h00);
      n = 0;
      repeat (40) begin tk(1); n += (alarm_n === 1'b0); end
      chk("disabled_alarm", 0, n);
      apb(1, MODE_OFS, 32'h01);
      // targets full idle, timer-alive idle, stop, then external clock with full idle and stop
      for (int t = 1; t < 6; t++) begin
         apb(1, POWER_OFS, (t == 4) ? 32'h05 : (t == 5) ? 32'h07 : 32'(t));
         halt_req <= 1;
         tk(1);
         halt_req <= 0;
         tk(3);
         chk("ctc_en", 32'(t == 2 || t > 3), 32'(ctc_en));
         chk("cpu_en", 0, 32'(cpu_en | grd_en | per_en));
         apb(0, STATUS_OFS, 32'h0);
         rd0 = rd;
         chk("pwr_state", 32'((t == 1) ? 1 : (t == 3) ? 3 : 2), (rd0 >> 2) & 32'h3);
         tk(6);
         apb(0, STATUS_OFS, 32'h0);
         chk("frozen_count", rd0 & 32'hFFFFFF00, rd & 32'hFFFFFF00);
         wake_req <= 1;
         tk(1);
         wake_req <= 0;
         tk(3);
         chk("run_again", 1, 32'(cpu_en & grd_en & per_en));
      end
      apb(1, POWER_OFS, 32'h0);
      apb(1, MISC_OFS, 32'h0);
      ext_low <= 1;
      tk(3);
      ext_low <= 0;
      pulse_low_count();
      chk("ext_stretch", EXT_RESET_CYCLES, n);
      tk(10);
      apb(1, MISC_OFS, 32'h08);
      tk(2);
      ext_low <= 1;
      tk(3);
      ext_low <= 0;
      pulse_low_count();
      chk("inhibit_drive", 0, n);
      stop_test();
   end
endmodule
`default_nettype wire
